// ==== hw/iodr_regs.vh ====
// Register offsets, field positions, reset values and timing counts for the inertial output registers
//
// Overview of operation
// - Angle registers are signed; zero is 0x0000
// - Angle step weight scales with decimation over rate
// - Clock mode 00 selects internal 2048 Hz rate
// - Other clock modes use the external clock
// - Angle codes span 0x7fff down to 0x8000
// - Primary acceleration is signed, 0.25 mg per step
// - Zero acceleration reads as 0x0000
// - Low-bits register holds filter bit growth
// - Primary is upper, low bits lower half
// - Each axis owns one primary, one low register
// - Acceleration registers at 0x10, 0x12, 0x14, 0x16
// - Angle registers at 0x26 and 0x28
// - Angle is displacement over one processing cycle
`ifndef IODR_REGS_VH
`define IODR_REGS_VH

// Register byte offsets, as carried in the command frame address field
`define IODR_ADDR_ACCX_LOW 7'h10
`define IODR_ADDR_ACCX_PRI 7'h12
`define IODR_ADDR_ACCY_LOW 7'h14
`define IODR_ADDR_ACCY_PRI 7'h16
`define IODR_ADDR_ANG_Y 7'h26
`define IODR_ADDR_ANG_Z 7'h28
`define IODR_ADDR_MSC 7'h32
`define IODR_ADDR_DEC 7'h36

// Control fields and reset values
`define IODR_CLKMODE_HI 3
`define IODR_CLKMODE_LO 2
`define IODR_CLKMODE_INT 2'h0
`define IODR_MSC_RST 16'h0000
`define IODR_DEC_W 11
`define IODR_DEC_RST 11'h000
`define IODR_ZERO16 16'h0000

// Angle code limits and accumulator width
`define IODR_ANG_MAX 16'h7fff
`define IODR_ANG_MIN 16'h8000
`define IODR_ACC_W 28
`define IODR_DIV_LAST 5'h1b

// Serial frame layout
`define IODR_FRAME_LAST 4'hf
`define IODR_CMD_WR_BIT 15

// Sample timing
`define IODR_CLK_HZ 100000000
`define IODR_FS_INT_HZ 2048
`define IODR_INT_TICK (`IODR_CLK_HZ / `IODR_FS_INT_HZ)

`endif

// ==== hw/iodr_angle_accum.v ====
// Delta angle accumulator for one axis with serial divide and saturation
`include "iodr_regs.vh"

module iodr_angle_accum (
  input wire clk, // System clock
  input wire sys_rst, // Asynchronous reset, active high
  input wire sampleStb, // One strobe per sample
  input wire [15:0] rate, // Rate sample, signed
  input wire [`IODR_DEC_W-1:0] decim, // Decimation setting
  output reg [15:0] angle_q // Delta angle code
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_DIV = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  reg [2:0] state_q;
  reg [`IODR_ACC_W-1:0] acc_q;
  reg [`IODR_DEC_W-1:0] cnt_q;
  reg [`IODR_ACC_W-1:0] quo_q;
  reg [12:0] rem_q;
  reg [11:0] divisor_q;
  reg neg_q;
  reg [4:0] step_q;
  wire [`IODR_ACC_W-1:0] accNew;
  wire [`IODR_ACC_W-1:0] accMag;
  wire [12:0] remShift;
  wire remFits;

  // Running sum of rate samples over the processing cycle
  assign accNew = acc_q + {{(`IODR_ACC_W-16){rate[15]}}, rate};
  assign accMag = accNew[`IODR_ACC_W-1] ? (~accNew + 28'h0000001) : accNew;
  assign remShift = {rem_q[11:0], quo_q[`IODR_ACC_W-1]};
  assign remFits = remShift >= {1'b0, divisor_q};

  ////////////////////////////////////////////////////////////////////////////
  // Accumulate, then divide the sum by decimation plus one
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      acc_q <= 28'h0000000;
      cnt_q <= `IODR_DEC_RST;
      quo_q <= 28'h0000000;
      rem_q <= 13'h0000;
      divisor_q <= 12'h001;
      neg_q <= 1'b0;
      step_q <= 5'h00;
      angle_q <= `IODR_ZERO16;
    end else begin
      // Sample bookkeeping runs even while a divide is in flight
      if (sampleStb) begin
        if (cnt_q >= decim) begin
          acc_q <= 28'h0000000;
          cnt_q <= `IODR_DEC_RST;
          neg_q <= accNew[`IODR_ACC_W-1];
          quo_q <= accMag;
          rem_q <= 13'h0000;
          divisor_q <= {1'b0, decim} + 12'h001;
          step_q <= 5'h00;
          state_q <= ST_DIV;
        end else begin
          acc_q <= accNew;
          cnt_q <= cnt_q + 11'h001;
        end
      end
      case (state_q)
        ST_IDLE: begin
          step_q <= 5'h00;
        end
        ST_DIV: begin
          if (!sampleStb) begin
            // Restoring divide, one quotient bit per clock
            rem_q <= remFits ? (remShift - {1'b0, divisor_q}) : remShift;
            quo_q <= {quo_q[`IODR_ACC_W-2:0], remFits};
            step_q <= step_q + 5'h01;
            if (step_q == `IODR_DIV_LAST) begin
              state_q <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          // Clamp to the signed 16-bit code range
          if (!neg_q && (quo_q > {12'h000, `IODR_ANG_MAX})) begin
            angle_q <= `IODR_ANG_MAX;
          end else if (neg_q && (quo_q > {12'h000, `IODR_ANG_MIN})) begin
            angle_q <= `IODR_ANG_MIN;
          end else if (neg_q) begin
            angle_q <= ~quo_q[15:0] + 16'h0001;
          end else begin
            angle_q <= quo_q[15:0];
          end
          if (!sampleStb) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // iodr_angle_accum

// ==== hw/iodr_top.v ====
// Inertial output register bank with serial register port and sample timing
`include "iodr_regs.vh"

module iodr_top #(
  parameter [31:0] INT_TICK_CYCLES = `IODR_INT_TICK // Clocks per internal sample
) (
  input wire clk, // System clock, 100 MHz
  input wire sys_rst, // Asynchronous reset, active high
  input wire spiCsN, // Serial chip select, active low
  input wire spiSclk, // Serial clock, idles high
  input wire spiMosi, // Serial data from host
  output reg spiMiso, // Serial data to host
  input wire extSampleClk, // External sample clock
  input wire [31:0] accelXIn, // X acceleration, primary and low halves
  input wire [31:0] accelYIn, // Y acceleration, primary and low halves
  input wire [15:0] gyroYIn, // Y rate sample
  input wire [15:0] gyroZIn, // Z rate sample
  output reg dataReady_q // Strobe when new samples are captured
);

  localparam [15:0] TICK_LAST = INT_TICK_CYCLES[15:0] - 16'h0001;
  localparam [1:0] SP_IDLE = 2'b01;
  localparam [1:0] SP_SHIFT = 2'b10;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  reg [15:0] mscCtrl_q;
  reg [`IODR_DEC_W-1:0] decim_q;
  reg [15:0] tickCnt_q;
  reg extPrev_q;
  reg sampleStb_q;
  reg [15:0] gyroY_q;
  reg [15:0] gyroZ_q;
  reg [15:0] accXPri_q;
  reg [15:0] accXLow_q;
  reg [15:0] accYPri_q;
  reg [15:0] accYLow_q;
  reg sclkPrev_q;
  reg [1:0] spState_q;
  reg [3:0] bitCnt_q;
  reg [15:0] rxShift_q;
  reg [15:0] txShift_q;
  reg [15:0] rdData_q;
  reg [15:0] rdMux;
  wire [15:0] angY;
  wire [15:0] angZ;
  wire [1:0] clkMode;
  wire intTick;
  wire extEdge;
  wire sampleTick;
  wire sclkRise;
  wire sclkFall;
  wire [15:0] rxWord;
  wire [6:0] rxAddr;
  wire rxIsWrite;

  ////////////////////////////////////////////////////////////////////////////
  // Sample rate selection
  assign clkMode = mscCtrl_q[`IODR_CLKMODE_HI:`IODR_CLKMODE_LO];
  assign intTick = (tickCnt_q == TICK_LAST);
  assign extEdge = extSampleClk & ~extPrev_q;
  assign sampleTick = (clkMode == `IODR_CLKMODE_INT) ? intTick : extEdge;

  // Internal sample divider, held at zero in external mode
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tickCnt_q <= 16'h0000;
      extPrev_q <= 1'b0;
    end else begin
      extPrev_q <= extSampleClk;
      if ((clkMode != `IODR_CLKMODE_INT) || intTick) begin
        tickCnt_q <= 16'h0000;
      end else begin
        tickCnt_q <= tickCnt_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample capture: both halves of each axis load on one edge
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sampleStb_q <= 1'b0;
      dataReady_q <= 1'b0;
      gyroY_q <= `IODR_ZERO16;
      gyroZ_q <= `IODR_ZERO16;
      accXPri_q <= `IODR_ZERO16;
      accXLow_q <= `IODR_ZERO16;
      accYPri_q <= `IODR_ZERO16;
      accYLow_q <= `IODR_ZERO16;
    end else begin
      sampleStb_q <= sampleTick;
      dataReady_q <= sampleTick;
      if (sampleTick) begin
        gyroY_q <= gyroYIn;
        gyroZ_q <= gyroZIn;
        accXPri_q <= accelXIn[31:16];
        accXLow_q <= accelXIn[15:0];
        accYPri_q <= accelYIn[31:16];
        accYLow_q <= accelYIn[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-axis delta angle accumulators
  iodr_angle_accum uAngY (
    .clk(clk),
    .sys_rst(sys_rst),
    .sampleStb(sampleStb_q),
    .rate(gyroY_q),
    .decim(decim_q),
    .angle_q(angY)
  );

  iodr_angle_accum uAngZ (
    .clk(clk),
    .sys_rst(sys_rst),
    .sampleStb(sampleStb_q),
    .rate(gyroZ_q),
    .decim(decim_q),
    .angle_q(angZ)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read decode by word address; unmapped words read as zero
  always @* begin
    rdMux = `IODR_ZERO16;
    case ({1'b0, rxAddr[6:1]})
      `IODR_ADDR_ACCX_LOW >> 1: begin
        rdMux = accXLow_q;
      end
      `IODR_ADDR_ACCX_PRI >> 1: begin
        rdMux = accXPri_q;
      end
      `IODR_ADDR_ACCY_LOW >> 1: begin
        rdMux = accYLow_q;
      end
      `IODR_ADDR_ACCY_PRI >> 1: begin
        rdMux = accYPri_q;
      end
      `IODR_ADDR_ANG_Y >> 1: begin
        rdMux = angY;
      end
      `IODR_ADDR_ANG_Z >> 1: begin
        rdMux = angZ;
      end
      `IODR_ADDR_MSC >> 1: begin
        rdMux = mscCtrl_q;
      end
      `IODR_ADDR_DEC >> 1: begin
        rdMux = {5'h00, decim_q};
      end
      default: begin
        rdMux = `IODR_ZERO16;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial port edge detection and frame fields
  assign sclkRise = spiSclk & ~sclkPrev_q;
  assign sclkFall = ~spiSclk & sclkPrev_q;
  assign rxWord = {rxShift_q[14:0], spiMosi};
  assign rxAddr = rxWord[14:8];
  assign rxIsWrite = rxWord[`IODR_CMD_WR_BIT];

  // Frame engine: sample on rising, drive on falling sclk
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclkPrev_q <= 1'b1;
      spState_q <= SP_IDLE;
      bitCnt_q <= 4'h0;
      rxShift_q <= 16'h0000;
      txShift_q <= 16'h0000;
      rdData_q <= 16'h0000;
      spiMiso <= 1'b0;
    end else begin
      sclkPrev_q <= spiSclk;
      case (spState_q)
        SP_IDLE: begin
          if (!spiCsN) begin
            spState_q <= SP_SHIFT;
            bitCnt_q <= 4'h0;
            rxShift_q <= 16'h0000;
            txShift_q <= rdData_q;
          end
        end
        SP_SHIFT: begin
          if (spiCsN) begin
            // Frame aborted or finished; partial frames are dropped
            spState_q <= SP_IDLE;
          end else if (sclkRise) begin
            rxShift_q <= rxWord;
            bitCnt_q <= bitCnt_q + 4'h1;
            if (bitCnt_q == `IODR_FRAME_LAST) begin
              // Read answer goes out in the following frame
              if (!rxIsWrite) begin
                rdData_q <= rdMux;
                txShift_q <= rdMux;
              end else begin
                txShift_q <= rdData_q;
              end
            end
          end else if (sclkFall) begin
            spiMiso <= txShift_q[15];
            txShift_q <= {txShift_q[14:0], 1'b0};
          end
        end
        default: begin
          spState_q <= SP_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte writes into the control registers; data registers ignore writes
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mscCtrl_q <= `IODR_MSC_RST;
      decim_q <= `IODR_DEC_RST;
    end else if ((spState_q == SP_SHIFT) && !spiCsN && sclkRise
                 && (bitCnt_q == `IODR_FRAME_LAST) && rxIsWrite) begin
      case (rxAddr)
        `IODR_ADDR_MSC: begin
          mscCtrl_q[7:0] <= rxWord[7:0];
        end
        `IODR_ADDR_MSC + 7'h01: begin
          mscCtrl_q[15:8] <= rxWord[7:0];
        end
        `IODR_ADDR_DEC: begin
          decim_q[7:0] <= rxWord[7:0];
        end
        `IODR_ADDR_DEC + 7'h01: begin
          decim_q[10:8] <= rxWord[2:0];
        end
        default: begin
          decim_q <= decim_q;
        end
      endcase
    end
  end

endmodule // iodr_top

// ==== bench/iodr_asserts.sv ====
// Port-level checker for the inertial output register bank
`include "iodr_regs.vh"
module iodr_asserts #(
  parameter [31:0] INT_TICK_CYCLES = `IODR_INT_TICK // Clocks per internal sample
) (
  input wire clk, // System clock
  input wire sys_rst, // Reset, active high
  input wire spiCsN, // Chip select, active low
  input wire spiSclk, // Serial clock
  input wire spiMosi, // Host data
  input wire spiMiso, // Device data
  input wire extSampleClk, // External sample clock
  input wire dataReady_q // Sample strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [3:0] bitCnt_q;
  reg [14:0] shift_q;
  reg extMode_q;
  reg [4:0] modeAge_q;
  reg [1:0] pulses_q;
  reg [31:0] gap_q;
  reg [3:0] extAge_q;
  reg [3:0] fallAge_q;
  reg sclkOld_q;
  reg extOld_q;
  wire settled = modeAge_q == 5'h1f;
  wire sclkRise = !spiCsN && spiSclk && !sclkOld_q;
  wire modeWr = sclkRise && bitCnt_q == 4'hf && shift_q[14] && shift_q[13:7] == `IODR_ADDR_MSC;
  ////////////////////////////////////////
  // Decode clock-mode writes and age the sample and serial edges
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bitCnt_q <= 4'h0;
      shift_q <= 15'h0;
      extMode_q <= 1'b0;
      modeAge_q <= 5'h0;
      pulses_q <= 2'h0;
      gap_q <= 32'h0;
      extAge_q <= 4'hf;
      fallAge_q <= 4'hf;
      sclkOld_q <= 1'b1;
      extOld_q <= 1'b0;
    end else begin
      sclkOld_q <= spiSclk;
      extOld_q <= extSampleClk;
      if (spiCsN) bitCnt_q <= 4'h0;
      else if (sclkRise) bitCnt_q <= bitCnt_q + 4'h1;
      if (sclkRise) shift_q <= {shift_q[13:0], spiMosi};
      if (modeWr) extMode_q <= |shift_q[2:1];
      if (modeWr) modeAge_q <= 5'h0;
      else if (!settled) modeAge_q <= modeAge_q + 5'h1;
      if (modeWr) pulses_q <= 2'h0;
      else if (dataReady_q && pulses_q != 2'h2) pulses_q <= pulses_q + 2'h1;
      gap_q <= dataReady_q ? 32'h0 : gap_q + 32'h1;
      extAge_q <= (extSampleClk && !extOld_q) ? 4'h0 : extAge_q + {3'h0, extAge_q != 4'hf};
      fallAge_q <= (!spiSclk && sclkOld_q) ? 4'h0 : fallAge_q + {3'h0, fallAge_q != 4'hf};
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  readyStrobe_a: assert property (dataReady_q |=> !dataReady_q) else $error("ready too long");
  intPeriod_a: assert property (dataReady_q && !extMode_q && pulses_q == 2'h2 |->
    gap_q == INT_TICK_CYCLES - 32'h1) else $error("internal period wrong");
  extTick_a: assert property (settled && extMode_q && $rose(extSampleClk) |->
    ##[1:6] dataReady_q) else $error("external sample missed");
  extCause_a: assert property (settled && extMode_q && dataReady_q |-> extAge_q <= 4'h6)
    else $error("sample without external edge");
  extSingle_a: assert property (settled && extMode_q && dataReady_q |=> !dataReady_q [*8])
    else $error("extra sample");
  misoHold_a: assert property (spiSclk [*3] |-> $stable(spiMiso)) else $error("data moved while high");
  misoCause_a: assert property ($changed(spiMiso) |-> fallAge_q <= 4'h6) else $error("data moved late");
  misoIdle_a: assert property (spiCsN [*4] |-> $stable(spiMiso)) else $error("data moved unselected");
  cover property (dataReady_q && !extMode_q && pulses_q == 2'h2);
  cover property (settled && extMode_q && dataReady_q);
  cover property (modeWr);
endmodule // iodr_asserts

bind iodr_top iodr_asserts #(.INT_TICK_CYCLES(INT_TICK_CYCLES)) chk (
  .clk, .sys_rst, .spiCsN, .spiSclk, .spiMosi, .spiMiso, .extSampleClk, .dataReady_q
);

// ==== bench/iodr_host.sv ====
// Host model that runs serial register frames
module iodr_host (
  input wire clk, // System clock
  output logic spiCsN, // Chip select, active low
  output logic spiSclk, // Serial clock, idles high
  output logic spiMosi, // Data to device
  input wire spiMiso, // Data from device
  output logic rxStb, // Checked frame finished
  output logic [15:0] rxWord // Word shifted in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus
  initial begin
    spiCsN = 1'b1;
    spiSclk = 1'b1;
    spiMosi = 1'b0;
    rxStb = 1'b0;
    rxWord = 16'h0;
  end
  // One 16-bit frame, clock idles high, five clocks per serial level
  task automatic xfer(input logic [15:0] tx, input logic chk);
    integer i;
    @(negedge clk);
    spiCsN = 1'b0;
    for (i = 15; i >= 0; i--) begin
      @(negedge clk);
      spiSclk = 1'b0;
      spiMosi = tx[i];
      repeat (5) @(negedge clk);
      spiSclk = 1'b1;
      rxWord[i] = spiMiso;
      repeat (4) @(negedge clk);
    end
    spiCsN = 1'b1;
    spiMosi = ~spiMosi; // Released line does not keep its last bit
    rxStb = chk;
    @(negedge clk);
    rxStb = 1'b0;
    repeat (4) @(negedge clk);
  endtask
endmodule // iodr_host

// ==== bench/inertial_output_data_registers_tb.sv ====
// Self-checking bench for the inertial output register bank
`include "iodr_regs.vh"
module inertial_output_data_registers_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 64;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic extSampleClk = 1'b0;
  logic [31:0] accelXIn = 32'h0;
  logic [31:0] accelYIn = 32'h0;
  logic [15:0] gyroYIn = 16'h0;
  logic [15:0] gyroZIn = 16'h0;
  logic [15:0] ya = 16'h0, yb = 16'h0, za = 16'h0, zb = 16'h0;
  logic ph = 1'b0;
  wire spiCsN, spiSclk, spiMosi, spiMiso, dataReady_q, rxStb;
  wire [15:0] rxWord;
  integer err_count = 0;
  integer n_compared = 0;
  integer seed = 32'h26c3;
  integer i, m;
  logic [15:0] expQ[$];
  always #5 clk = ~clk;
  iodr_top #(.INT_TICK_CYCLES(TICK)) uut (
    .clk(clk), .sys_rst(sys_rst), .spiCsN(spiCsN), .spiSclk(spiSclk), .spiMosi(spiMosi),
    .spiMiso(spiMiso), .extSampleClk(extSampleClk), .accelXIn(accelXIn), .accelYIn(accelYIn),
    .gyroYIn(gyroYIn), .gyroZIn(gyroZIn), .dataReady_q(dataReady_q)
  );
  iodr_host host (
    .clk(clk), .spiCsN(spiCsN), .spiSclk(spiSclk), .spiMosi(spiMosi), .spiMiso(spiMiso),
    .rxStb(rxStb), .rxWord(rxWord)
  );
  ////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      err_count++;
    end
  endtask
  // Read command, then a second frame carries the answer
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    host.xfer({1'b0, a, 8'h00}, 1'b0);
    expQ.push_back(e);
    host.xfer(16'h0000, 1'b1);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer({1'b1, a, d}, 1'b0);
  endtask
  // Mean of two rate codes, rounded toward zero
  function automatic logic [15:0] mean2(input logic [15:0] a, input logic [15:0] b);
    int s;
    s = $signed(a) + $signed(b);
    s = s / 2;
    return s[15:0];
  endfunction
  task give_verdict;
    $display("Compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Compare each answer with the oldest expectation
  always @(posedge clk) begin
    if (rxStb === 1'b1 && expQ.size() > 0) check(rxWord, expQ.pop_front());
  end
  // External sample clock, 40 clocks a period; rates alternate each sample
  always begin
    repeat (20) @(negedge clk);
    extSampleClk = ~extSampleClk;
    if (!extSampleClk) begin
      ph = ~ph;
      gyroYIn = ph ? ya : yb;
      gyroZIn = ph ? za : zb;
    end
  end
  // Hang guard
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    give_verdict;
  end
  ////////////////////////////////////////
  initial begin
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    rd(`IODR_ADDR_MSC, 16'h0000);
    rd(`IODR_ADDR_DEC, 16'h0000);
    rd(7'h00, 16'h0000);
    // Zero first, then random acceleration words
    for (i = 0; i < 4; i++) begin
      accelXIn = (i == 0) ? 32'h0 : $random(seed);
      accelYIn = (i == 0) ? 32'h0 : $random(seed);
      repeat (2 * TICK) @(negedge clk);
      rd(`IODR_ADDR_ACCX_LOW, accelXIn[15:0]);
      rd(`IODR_ADDR_ACCX_PRI, accelXIn[31:16]);
      rd(`IODR_ADDR_ACCY_LOW, accelYIn[15:0]);
      rd(`IODR_ADDR_ACCY_PRI, accelYIn[31:16]);
    end
    // Internal rate, no decimation, code limits
    ya = 16'h7fff;
    yb = 16'h7fff;
    za = 16'h8000;
    zb = 16'h8000;
    repeat (200) @(negedge clk);
    rd(`IODR_ADDR_ANG_Y, 16'h7fff);
    rd(`IODR_ADDR_ANG_Z, 16'h8000);
    // External clock modes with two samples per cycle
    wr(`IODR_ADDR_DEC, 8'h01);
    for (m = 1; m < 4; m++) begin
      {ya, yb} = $random(seed);
      {za, zb} = $random(seed);
      wr(`IODR_ADDR_MSC, {4'h0, m[1:0], 2'h0});
      repeat (480) @(negedge clk);
      rd(`IODR_ADDR_MSC, {12'h0, m[1:0], 2'h0});
      rd(`IODR_ADDR_ANG_Y, mean2(ya, yb));
      rd(`IODR_ADDR_ANG_Z, mean2(za, zb));
    end
    rd(`IODR_ADDR_DEC, 16'h0001);
    // High control bytes: decimation bits above 7 and the upper half of the mode word
    wr(`IODR_ADDR_DEC + 7'h01, 8'h07);
    wr(`IODR_ADDR_MSC + 7'h01, 8'h5a);
    rd(`IODR_ADDR_DEC, 16'h0701);
    rd(`IODR_ADDR_MSC, 16'h5a0c);
    give_verdict;
  end
endmodule // inertial_output_data_registers_tb
